/* File: logic/flash_writer_cfg.svh */
// Register map, field positions and timing figures of the flash writer.
// Assumes a 50 MHz pclk and a 32-bit APB register bus.
`ifndef FLASH_WRITER_CFG_SVH
`define FLASH_WRITER_CFG_SVH

// Register byte offsets
`define OFS_PTR_LOW    8'h00
`define OFS_PTR_HIGH   8'h04
`define OFS_PTR_UPPER  8'h08
`define OFS_LATCH      8'h0c
`define OFS_TBL_WRITE  8'h10
`define OFS_FLASH_CTL  8'h14
`define OFS_UNLOCK_KEY 8'h18
`define OFS_INT_CTL    8'h1c
`define OFS_IRQ_STAT   8'h20
`define OFS_IRQ_MASK   8'h24

// Flash control field positions
`define CTL_ERASE_SEL  4
`define CTL_ABORT      3
`define CTL_ARM        2
`define CTL_START      1
// Global interrupt enable bit in the interrupt control register
`define INT_GIE        7

// Unlock key values
`define KEY_FIRST      8'h55
`define KEY_SECOND     8'haa

// Table write modes (table write register bits 1:0)
`define TW_KEEP        2'h0
`define TW_POST_INC    2'h1
`define TW_POST_DEC    2'h2
`define TW_PRE_INC     2'h3

// Interrupt status bits
`define IRQ_DONE       0
`define IRQ_ABORT      1
`define IRQ_REFUSED    2

// Timing
`define CLK_MHZ        50
`define PROG_TIME_US   2000
`define ERASE_TIME_US  2000

`endif

/* File: logic/flash_writer_pkg.sv */
// Types shared by the flash writer: sequencer states and the state record.
// Constants live in flash_writer_cfg.svh.
package flash_writer_pkg;

    // Long-write sequencer
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_PROG  = 2'b01,
        ST_ERASE = 2'b10
    } seq_e;

    // Unlock key progress
    typedef enum logic [1:0] {
        KEY_LOCKED = 2'b00,
        KEY_HALF   = 2'b01,
        KEY_OPEN   = 2'b10
    } key_e;

    // Flash control bits
    typedef struct packed {
        logic erase_sel;
        logic write_abort_flag;
        logic write_arm;
        logic write_start;
    } flash_ctl_s;

    // Whole state of the writer
    typedef struct packed {
        logic [63:0][7:0] hold;
        logic [21:0]      table_pointer;
        logic [7:0]       table_data_latch;
        flash_ctl_s       ctl;
        key_e             key;
        logic             global_irq_enable;
        logic [2:0]       irq_stat;
        logic [2:0]       irq_mask;
        seq_e             seq;
        logic [19:0]      timer;
        logic [21:0]      flash_addr;
        logic [31:0]      prdata;
        logic [7:0]       hold_rd_data;
        logic [1:0]       master_clear_reset_sync;
        logic [1:0]       wdt_sync;
    } state_s;

endpackage : flash_writer_pkg

/* File: logic/flash_writer.sv */
// Self-programming write sequencer for on-chip program flash, APB slave.
// Assumes an APB master on pclk and a flash macro that follows the
// prog/erase levels; reset events arrive as asynchronous pins.
//
// Overview of operation
// - Sixty-four bytes loaded by table writes.
// - No start unless write arm is set.
// - Key 55h then AAh, then start.
// - Start runs timed long write, stalls CPU.
// - Reset during write sets abort flag.
// - Start without key sequence is refused and flagged.
// - Control bits: erase 4, error 3, arm 2, start 1.
// - Key register stores nothing readable.
// - Pointer split into upper, high, low bytes.
// - Pre-increment write bumps pointer, then stores.
// - Erase select makes start a block erase.
// - Holding registers keep data after write.
// - Erase uses pointer bits above bit nine.
//
// Notes for users of the block:
// The timer counts pclk cycles at CLK_MHZ.
// A different clock scales both long times.
// Writes during a long operation are lost;
// the core issuing them is stalled anyway.
// Reads never wait; prdata is registered.
// The key relocks after any other write to a mapped offset,
// so the start must follow the keys at once.
// An abort ends the operation early and
// leaves the row half programmed: software
// checks the abort flag and writes it again.
// Holding bytes survive a write, so stale
// data is programmed unless overwritten.
// The abort flag is cleared by presetn and
// by writing zero; a set always wins.
`timescale 1ns/1ps
`default_nettype none
`include "flash_writer_cfg.svh"

module flash_writer
    import flash_writer_pkg::*;
#(
    parameter int unsigned PROG_TIME_US  = `PROG_TIME_US,
    parameter int unsigned ERASE_TIME_US = `ERASE_TIME_US
) (
    // Clock, reset, enable
    // Enable low freezes all state
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave
    // No wait states: pready tied high
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Reset events from outside the clock domain
    // Levels, synchronised inside
    input  wire logic        master_clear_reset,
    input  wire logic        watchdog,
    // Flash macro side
    // Operation levels and start address
    output logic             cpu_stall,
    output logic             flash_prog,
    output logic             flash_erase,
    output logic [21:0]      flash_addr,
    input  wire logic [5:0]  hold_rd_idx,
    output logic [7:0]       hold_rd_data,
    // Interrupt
    // Level, high on unmasked status
    output logic             irq
);

    // Cycle counts of the long operations, derived from their times
    // The 20-bit timer covers the default 100000 cycles;
    // times above 1048575 cycles need a wider timer field.
    localparam int unsigned PROG_CYCLES  = PROG_TIME_US * `CLK_MHZ;
    localparam int unsigned ERASE_CYCLES = ERASE_TIME_US * `CLK_MHZ;

    // One record holds the whole block,
    // so one register process keeps it
    state_s state_reg;  // Registered state
    state_s state_next; // Next state

    // Decoded bus phases
    // First cycle of a transfer
    logic setup_ph;
    // Write landing at this edge
    logic write_acc;
    // Only the low byte is used
    logic [7:0] wbyte;
    // Reset event while busy
    logic abort_evt;

    // True for an offset the register file answers
    // Shared by error response and write decode
    function automatic logic addr_ok(input logic [7:0] a);
        case (a)
            `OFS_PTR_LOW, `OFS_PTR_HIGH, `OFS_PTR_UPPER, `OFS_LATCH,
            `OFS_TBL_WRITE, `OFS_FLASH_CTL, `OFS_UNLOCK_KEY,
            `OFS_INT_CTL, `OFS_IRQ_STAT, `OFS_IRQ_MASK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction : addr_ok

    // Read view of one register
    function automatic logic [31:0] rd_mux(input state_s s,
                                           input logic [7:0] a);
        case (a)
            `OFS_PTR_LOW:    rd_mux = {24'h0, s.table_pointer[7:0]};
            `OFS_PTR_HIGH:   rd_mux = {24'h0, s.table_pointer[15:8]};
            `OFS_PTR_UPPER:  rd_mux = {26'h0, s.table_pointer[21:16]};
            `OFS_LATCH:      rd_mux = {24'h0, s.table_data_latch};
            `OFS_FLASH_CTL:  rd_mux = {27'h0, s.ctl, 1'b0};
            `OFS_INT_CTL:    rd_mux = {24'h0, s.global_irq_enable, 7'h0};
            `OFS_IRQ_STAT:   rd_mux = {29'h0, s.irq_stat};
            `OFS_IRQ_MASK:   rd_mux = {29'h0, s.irq_mask};
            // key register has no readable contents
            default:         rd_mux = 32'h0;
        endcase
    endfunction : rd_mux

    // Combinational handshake: reads are prepared in the setup cycle,
    // so every access completes with no wait states
    assign pready  = 1'b1;
    // Unmapped offsets answer with an error
    // and leave every register alone
    assign pslverr = psel & penable & ~addr_ok(paddr);

    assign setup_ph  = psel & ~penable;
    assign write_acc = psel & penable & pwrite & addr_ok(paddr);
    assign wbyte     = pwdata[7:0];

    // Registered outputs
    assign prdata       = state_reg.prdata;
    assign cpu_stall    = (state_reg.seq != ST_IDLE);
    assign flash_prog   = (state_reg.seq == ST_PROG);
    assign flash_erase  = (state_reg.seq == ST_ERASE);
    assign flash_addr   = state_reg.flash_addr;
    assign hold_rd_data = state_reg.hold_rd_data;
    // Both inputs registered, so no glitches
    assign irq          = |(state_reg.irq_stat & state_reg.irq_mask);

    // A long event pulse aborts once only:
    // the block is idle on the next cycle
    // a synchronised reset event while busy aborts the operation
    assign abort_evt = (state_reg.seq != ST_IDLE) &
                       (state_reg.master_clear_reset_sync[1] | state_reg.wdt_sync[1]);

    // Next-state logic
    // Later assignments override earlier
    // ones, so sequencer events beat writes
    always_comb begin
        state_next = state_reg;

        // Two-flop synchronisers for the reset event pins
        // Only the second stage is read, so a
        // metastable first stage stays inside
        state_next.master_clear_reset_sync = {state_reg.master_clear_reset_sync[0], master_clear_reset};
        state_next.wdt_sync  = {state_reg.wdt_sync[0], watchdog};

        // Holding register read port for the flash macro
        // Index is on pclk: no synchroniser
        state_next.hold_rd_data = state_reg.hold[hold_rd_idx];

        // Read data captured in the setup cycle
        // It then stands through the access
        // phase, which lets pready stay high
        if (setup_ph && !pwrite) begin
            state_next.prdata = rd_mux(state_reg, paddr);
        end

        // Any mapped write other than the expected next key step relocks.
        // Writes are ignored while busy: the core is stalled anyway.
        if (write_acc && state_reg.seq == ST_IDLE) begin
            if (paddr != `OFS_UNLOCK_KEY) begin
                state_next.key = KEY_LOCKED;
            end
            case (paddr)
                `OFS_PTR_LOW: begin
                    state_next.table_pointer[7:0] = wbyte;
                end
                // Middle pointer byte
                `OFS_PTR_HIGH: begin
                    state_next.table_pointer[15:8] = wbyte;
                end
                // Top byte keeps six bits
                `OFS_PTR_UPPER: begin
                    state_next.table_pointer[21:16] = wbyte[5:0];
                end
                // Byte for the next table write
                `OFS_LATCH: begin
                    state_next.table_data_latch = wbyte;
                end
                // short write of the latch into a holding register
                `OFS_TBL_WRITE: begin
                    // Low two bits pick the step
                    case (wbyte[1:0])
                        `TW_PRE_INC: begin
                            state_next.table_pointer =
                                state_reg.table_pointer + 22'h1;
                            state_next.hold[state_next.table_pointer[5:0]] =
                                state_reg.table_data_latch;
                        end
                        // Store, then step on
                        `TW_POST_INC: begin
                            state_next.hold[state_reg.table_pointer[5:0]] =
                                state_reg.table_data_latch;
                            state_next.table_pointer =
                                state_reg.table_pointer + 22'h1;
                        end
                        // Store, then step back
                        `TW_POST_DEC: begin
                            state_next.hold[state_reg.table_pointer[5:0]] =
                                state_reg.table_data_latch;
                            state_next.table_pointer =
                                state_reg.table_pointer - 22'h1;
                        end
                        // Plain store
                        default: begin
                            state_next.hold[state_reg.table_pointer[5:0]] =
                                state_reg.table_data_latch;
                        end
                    endcase
                end
                // key register only advances the unlock sequence
                `OFS_UNLOCK_KEY: begin
                    // keys only count with interrupts disabled
                    // Wrong value or order relocks
                    if (!state_reg.global_irq_enable &&
                        state_reg.key == KEY_LOCKED && wbyte == `KEY_FIRST) begin
                        state_next.key = KEY_HALF;
                    end else if (!state_reg.global_irq_enable &&
                                 state_reg.key == KEY_HALF &&
                                 wbyte == `KEY_SECOND) begin
                        state_next.key = KEY_OPEN;
                    end else begin
                        state_next.key = KEY_LOCKED;
                    end
                end
                `OFS_FLASH_CTL: begin
                    // Arm and erase follow the byte
                    state_next.ctl.erase_sel = wbyte[`CTL_ERASE_SEL];
                    state_next.ctl.write_arm = wbyte[`CTL_ARM];
                    // Error flag is cleared by writing zero; writing one keeps it
                    state_next.ctl.write_abort_flag =
                        state_reg.ctl.write_abort_flag & wbyte[`CTL_ABORT];
                    if (wbyte[`CTL_START]) begin
                        // start needs arm and a fresh unlock
                        if (wbyte[`CTL_ARM] && state_reg.key == KEY_OPEN) begin
                            state_next.ctl.write_start = 1'b1;
                            if (wbyte[`CTL_ERASE_SEL]) begin
                                // block erase, low ten bits dropped
                                state_next.seq = ST_ERASE;
                                state_next.timer = ERASE_CYCLES[19:0];
                                state_next.flash_addr =
                                    {state_reg.table_pointer[21:10], 10'h0};
                            end else begin
                                state_next.seq = ST_PROG;
                                state_next.timer = PROG_CYCLES[19:0];
                                state_next.flash_addr =
                                    {state_reg.table_pointer[21:6], 6'h0};
                            end
                        end else begin
                            // Refused start: start bit stays low
                            state_next.irq_stat[`IRQ_REFUSED] = 1'b1;
                        end
                    end
                end
                // Keys only count while low
                `OFS_INT_CTL: begin
                    state_next.global_irq_enable = wbyte[`INT_GIE];
                end
                `OFS_IRQ_STAT: begin
                    // Write one to clear
                    state_next.irq_stat = state_reg.irq_stat & ~wbyte[2:0];
                end
                // Same layout as the status
                `OFS_IRQ_MASK: begin
                    state_next.irq_mask = wbyte[2:0];
                end
                // No write effect elsewhere
                default: begin
                end
            endcase
        end

        // Long operation sequencer
        case (state_reg.seq)
            // Idle: only a bus write starts work
            ST_IDLE: begin
            end
            ST_PROG, ST_ERASE: begin
                // Abort first: it beats the timer
                if (abort_evt) begin
                    // abort flags the error and ends the cycle
                    state_next.ctl.write_abort_flag = 1'b1;
                    state_next.ctl.write_start = 1'b0;
                    state_next.irq_stat[`IRQ_ABORT] = 1'b1;
                    state_next.seq = ST_IDLE;
                    state_next.key = KEY_LOCKED;
                end else if (state_reg.timer <= 20'h1) begin
                    // clear start and release stall together
                    // holding registers are left as they are
                    state_next.ctl.write_start = 1'b0;
                    state_next.irq_stat[`IRQ_DONE] = 1'b1;
                    state_next.seq = ST_IDLE;
                    state_next.key = KEY_LOCKED;
                end else begin
                    // One cycle of the long write
                    state_next.timer = state_reg.timer - 20'h1;
                end
            end
            // Unused code falls back to idle
            default: begin
                state_next.seq = ST_IDLE;
            end
        endcase
    end

    // State register; clk_en low freezes everything
    // Reset clears all: key locked, no
    // operation running afterwards
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

endmodule : flash_writer
`default_nettype wire

/* File: test/flash_writer_monitor.sv */
// Port assertions for the flash writer, bound into every instance.
// Assumes an APB master that spaces its writes three cycles apart.
`timescale 1ns/1ps
`default_nettype none
module flash_writer_monitor #(
    parameter int unsigned PROG_TIME_US  = 1,
    parameter int unsigned ERASE_TIME_US = 1
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Events and flash side
    input wire logic        master_clear_reset,
    input wire logic        watchdog,
    input wire logic        cpu_stall,
    input wire logic        flash_prog,
    input wire logic        flash_erase,
    input wire logic [21:0] flash_addr
);
    localparam int PC = PROG_TIME_US * 50;  // Program length in cycles
    localparam int EC = ERASE_TIME_US * 50; // Erase length in cycles
    logic [11:0] cnt; // Stall cycles so far
    logic        ab;  // Event seen; reset value 1 masks the first fall
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Count stall length and note reset events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            ab  <= 1'b1;
        end else begin
            cnt <= cpu_stall ? cnt + 12'h001 : 12'h000;
            ab  <= cpu_stall & (ab | master_clear_reset | watchdog);
        end
    end
    sequence s_key(d);
        psel && penable && pwrite && paddr == 8'h18 && pwdata[7:0] == d;
    endsequence
    sequence s_go;
        psel && penable && pwrite && paddr == 8'h14 && pwdata[2:1] == 2'b11 && !cpu_stall;
    endsequence
    a_key_start: assert property (s_key(8'h55) ##3 s_key(8'haa) ##3 s_go |-> ##[1:2] cpu_stall)
        else $error("unlocked start did not stall");
    a_no_arm: assert property (psel && penable && pwrite && paddr == 8'h14 && pwdata[2:1] == 2'b01
        && !cpu_stall |=> !cpu_stall [*3])
        else $error("start without arm ran");
    a_op_len: assert property ($fell(cpu_stall) && !ab |-> cnt == ($past(flash_erase) ? EC : PC))
        else $error("long write length wrong");
    a_stall_kind: assert property (cpu_stall ? flash_prog ^ flash_erase : !(flash_prog || flash_erase))
        else $error("stall and operation disagree");
    a_erase_block: assert property ($rose(flash_erase) |-> flash_addr[9:0] == 10'h000)
        else $error("erase address not block aligned");
    a_addr_hold: assert property (cpu_stall && $past(cpu_stall) |-> $stable(flash_addr))
        else $error("flash address moved in operation");
    a_abort_end: assert property (cpu_stall && (master_clear_reset || watchdog) |-> ##[1:4] !cpu_stall)
        else $error("reset event did not end operation");
    a_key_reads: assert property (psel && penable && !pwrite && paddr == 8'h18 |-> prdata == 32'h0)
        else $error("key register read not zero");
    a_ctl_unused: assert property (psel && penable && !pwrite && paddr == 8'h14
        |-> prdata[31:5] == 27'h0 && !prdata[0])
        else $error("control unused bits not zero");
    a_upper_bits: assert property (psel && penable && !pwrite && paddr == 8'h08 |-> prdata[31:6] == 26'h0)
        else $error("upper pointer byte too wide");
endmodule : flash_writer_monitor
bind flash_writer flash_writer_monitor #(
    .PROG_TIME_US(PROG_TIME_US), .ERASE_TIME_US(ERASE_TIME_US)
) mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .master_clear_reset(master_clear_reset),
    .watchdog(watchdog), .cpu_stall(cpu_stall), .flash_prog(flash_prog),
    .flash_erase(flash_erase), .flash_addr(flash_addr)
);
`default_nettype wire

/* File: test/flash_core_model.sv */
// Core model: APB master doing register and table writes.
// Assumes pready is sampled at rising pclk edges only.
`timescale 1ns/1ps
`default_nettype none
module flash_core_model (
    // Clock
    input  wire logic        pclk,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic err; // Error flag of the last transfer
    // Idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end
    // One transfer; released address and data lines carry inverted values, pwrite keeps its last one
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, a, {24'h0, d}, r);
    endtask : wr
    // interrupts off first, then arm, keys, then start at once
    task automatic go(input logic [7:0] c);
        wr(8'h1c, 8'h00);
        wr(8'h14, c & 8'hfd);
        wr(8'h18, 8'h55);
        wr(8'h18, 8'haa);
        wr(8'h14, c);
    endtask : go
endmodule : flash_core_model
`default_nettype wire

/* File: test/flash_self_program_writer_tb.sv */
// Self-checking bench of the flash writer with a core model on APB.
// Assumes short timing parameters: a long write lasts 50 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %0t got %h expected %h", $time, g, e); end end
module flash_self_program_writer_tb;
    localparam int PT = 1;       // Long-write time in microseconds
    localparam int PC = PT * 50; // Long-write length in cycles
    logic pclk = 1'b0, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic master_clear_reset, watchdog, cpu_stall, flash_prog, flash_erase, irq;
    logic [7:0]  paddr, hold_rd_data, hold_exp [64];
    logic [31:0] pwdata, prdata, seed, r;
    logic [21:0] flash_addr, adr;
    logic [5:0]  hold_rd_idx;
    int          bad_count = 0, total_checks = 0, n;
    flash_writer #(.PROG_TIME_US(PT), .ERASE_TIME_US(PT)) DUT (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .master_clear_reset(master_clear_reset), .watchdog(watchdog),
        .cpu_stall(cpu_stall), .flash_prog(flash_prog), .flash_erase(flash_erase),
        .flash_addr(flash_addr), .hold_rd_idx(hold_rd_idx), .hold_rd_data(hold_rd_data), .irq(irq));
    flash_core_model core (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Clock at 50 MHz
    always #10 pclk = ~pclk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        core.xfer(1'b0, a, 32'h0, v);
        `CHK(v, e)
    endtask : rd_chk
    // Bounded wait for a stall, then its length in cycles
    task automatic measure(output int len, output logic [21:0] a);
        len = 0;
        for (int i = 0; i < 10 && cpu_stall !== 1'b1; i++) @(posedge pclk);
        a = flash_addr;
        while (cpu_stall === 1'b1 && len < 4000) begin
            @(posedge pclk);
            len++;
        end
    endtask : measure
    task automatic chk_hold();
        for (int i = 0; i < 64; i++) begin
            @(posedge pclk);
            hold_rd_idx <= i[5:0];
            repeat (2) @(posedge pclk);
            `CHK(hold_rd_data, hold_exp[i])
        end
    endtask : chk_hold
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    // Watchdog against a hung run
    initial begin
        #(20 * 20000);
        bad_count++;
        stop_test();
    end
    // Scenarios
    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        master_clear_reset = 1'b0;
        watchdog = 1'b0;
        hold_rd_idx = 6'h00;
        seed = 32'd86;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(8'h14, 32'h0);
        rd_chk(8'h18, 32'h0);
        core.xfer(1'b0, 8'h28, 32'h0, r);
        `CHK(core.err, 1'b1)
        core.wr(8'h00, 8'hff);
        core.wr(8'h04, 8'h23);
        core.wr(8'h08, 8'h01);
        // Erase the block first; low ten pointer bits ignored
        core.go(8'h16);
        measure(n, adr);
        `CHK(n, PC)
        `CHK(adr, 22'h012000)
        $display("test erase done");
        for (int i = 0; i < 64; i++) begin
            seed = xs(seed);
            hold_exp[i] = seed[7:0];
            core.wr(8'h0c, seed[7:0]);
            core.wr(8'h10, 8'h03);
        end
        rd_chk(8'h00, 32'h3f);
        rd_chk(8'h04, 32'h24);
        rd_chk(8'h08, 32'h01);
        // Other table write modes; pointer ends back in the row
        core.wr(8'h0c, 8'h5a);
        core.wr(8'h10, 8'h01);
        core.wr(8'h10, 8'h02);
        core.wr(8'h10, 8'h00);
        hold_exp[0] = 8'h5a;
        hold_exp[63] = 8'h5a;
        rd_chk(8'h00, 32'h3f);
        chk_hold();
        $display("test load done");
        core.go(8'h02);
        measure(n, adr);
        `CHK(n, 0)
        rd_chk(8'h20, 32'h5);
        core.wr(8'h20, 8'h07);
        core.wr(8'h14, 8'h06);
        measure(n, adr);
        `CHK(n, 0)
        rd_chk(8'h14, 32'h04);
        core.wr(8'h20, 8'h07);
        $display("test refuse done");
        core.wr(8'h24, 8'h01);
        core.go(8'h06);
        measure(n, adr);
        `CHK(n, PC)
        `CHK(adr, 22'h012400)
        `CHK(irq, 1'b1)
        rd_chk(8'h14, 32'h04);
        chk_hold();
        core.wr(8'h24, 8'h00);
        @(posedge pclk);
        `CHK(irq, 1'b0)
        core.wr(8'h20, 8'h01);
        rd_chk(8'h20, 32'h0);
        core.wr(8'h14, 8'h00);
        $display("test program done");
        for (int s = 0; s < 2; s++) begin
            core.go(8'h06);
            repeat (10) @(posedge pclk);
            if (s == 0) master_clear_reset <= 1'b1;
            else watchdog <= 1'b1;
            repeat (6) @(posedge pclk);
            `CHK(cpu_stall, 1'b0)
            master_clear_reset <= 1'b0;
            watchdog <= 1'b0;
            core.xfer(1'b0, 8'h14, 32'h0, r);
            `CHK(r[3], 1'b1)
            core.xfer(1'b0, 8'h20, 32'h0, r);
            `CHK(r[1], 1'b1)
            core.wr(8'h14, 8'h00);
            core.wr(8'h20, 8'h07);
            rd_chk(8'h14, 32'h0);
        end
        $display("test abort done");
        stop_test();
    end
endmodule : flash_self_program_writer_tb
`default_nettype wire
